// ==== include/sdp_pkg.sv ====
// Constants, register map and field layout of the sinc3 decimation path.
// Assumes a 40 MHz system clock; modulator pulses come from a divider.
package sdp_pkg;
   localparam int          CLK_HZ        = 40000000;
   localparam int          DEV_CLK_HZ    = 512000;
   localparam int          DEV_CLK_FAST  = 2048000;
   localparam int          MOD_CLK_HZ    = 128000;
   // Device clock tick derived from system clock (rounded down)
   localparam logic [7:0]  DEV_TICK_DIV  = 8'(CLK_HZ / DEV_CLK_HZ);
   localparam logic [7:0]  DEV_TICK_FDIV = 8'(CLK_HZ / DEV_CLK_FAST);
   localparam logic [4:0]  MOD_DIV_SLOW  = 5'h04;
   localparam logic [4:0]  MOD_DIV_FAST  = 5'h10;
   localparam int          NUM_CH        = 2;
   localparam int          ACC_W         = 32;
   localparam int          OUT_W         = 16;
   localparam int          SETTLE_PER    = 3;
   localparam int          FIFO_DEPTH    = 4;
   // Word offsets on the bus (byte addresses)
   localparam logic [7:0]  CFG1_OFF      = 8'h04;
   localparam logic [7:0]  GAIN1_OFF     = 8'h10;
   localparam logic [7:0]  GAIN2_OFF     = 8'h14;
   localparam logic [7:0]  LDSTAT_OFF    = 8'h0c;
   localparam logic [7:0]  CTRL_OFF      = 8'h20;
   localparam logic [7:0]  STAT_OFF      = 8'h24;
   localparam logic [7:0]  DATA_OFF      = 8'h28;
   // Fields
   localparam int          RATE_LSB      = 0;
   localparam int          GAIN_LSB      = 4;
   localparam int          CLKDIV_BIT    = 6;
   localparam int          CHOP_LSB      = 0;
   localparam logic [2:0]  RATE_RST      = 3'h2;
   localparam logic [2:0]  GAIN_RST      = 3'h0;
   localparam logic [1:0]  CHOP_RST      = 2'h0;
   localparam logic [15:0] POS_FS        = 16'h7fff;
   localparam logic [15:0] NEG_FS        = 16'h8000;
   typedef enum logic [1:0] {SDP_IDLE, SDP_SETTLE, SDP_RUN} sdp_state_t;
endpackage

// ==== src/sdp_fifo.sv ====
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module sdp_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
) (
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic      [WIDTH-1:0] outData,
   output logic                  outValid,
   input  wire logic             outReady
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wrPtr_ff, rdPtr_ff;
   logic [AW:0]      count_ff;
   wire              doWr = inValid && inReady;
   wire              doRd = outValid && outReady;
   assign inReady  = (count_ff != (AW+1)'(DEPTH));
   assign outValid = (count_ff != '0);
   assign outData  = mem_ff[rdPtr_ff];
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
         count_ff <= '0;
      end else begin
         if (doWr) wrPtr_ff <= AW'(wrPtr_ff + 1'b1);
         if (doRd) rdPtr_ff <= AW'(rdPtr_ff + 1'b1);
         count_ff <= (AW+1)'(count_ff + doWr - doRd);
      end
   end
   always_ff @(posedge clk) begin
      if (doWr) mem_ff[wrPtr_ff] <= inData;
   end
endmodule
`default_nettype wire

// ==== src/sdp_sinc3_path.sv ====
// Two-channel sinc3 decimation path with Wishbone register slave.
// Assumes modulator bits synchronous to clk, read on each modTick pulse.
// Notes on behaviour
// - Seven gains per channel via setting register
// - Modulator clock is device clock over 4/16
// - Per-channel second-order modulator bitstream input
// - Decimator is third-order sinc, ratio N
// - Data-rate field global across channels
// - One modulator bit per modulator tick
// - Step settles within three output periods
// - First result after start waits settling
// - Chopping at 8, 32 or 64 kSPS
// - Device clock 512 kHz or 2.048 MHz
// - Output saturates at 7fff and 8000
`timescale 1ns/1ps
`default_nettype none
module sdp_sinc3_path
   import sdp_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   output logic             wb_ack_o,
   input  wire logic        startIn,
   input  wire logic [1:0]  modBit,
   output logic             modTick_ff,
   output logic             chopTick_ff,
   output logic [2:0]       gainSel1_ff,
   output logic [2:0]       gainSel2_ff
);
   // Decimation ratio per data-rate code: 128 kHz/N = 8000..125 SPS
   function automatic logic [9:0] ratioOf(input logic [2:0] code);
      case (code)
         3'h0:    ratioOf = 10'h010;
         3'h1:    ratioOf = 10'h020;
         3'h2:    ratioOf = 10'h040;
         3'h3:    ratioOf = 10'h080;
         3'h4:    ratioOf = 10'h100;
         3'h5:    ratioOf = 10'h200;
         3'h6:    ratioOf = 10'h400 - 10'h001;
         default: ratioOf = 10'h200;
      endcase
   endfunction
   // Gain codes 0..6 map to 1,2,3,4,6,8,12; code 7 is refused
   function automatic logic [2:0] gainClamp(input logic [2:0] code,
                                            input logic [2:0] old);
      gainClamp = (code == 3'h7) ? old : code;
   endfunction
   // Right shift that maps full scale N^3 onto 2^15; N=16 shifts left
   function automatic logic [4:0] shiftOf(input logic [2:0] code);
      case (code)
         3'h0:    shiftOf = 5'h00;
         3'h1:    shiftOf = 5'h00;
         3'h2:    shiftOf = 5'h03;
         3'h3:    shiftOf = 5'h06;
         3'h4:    shiftOf = 5'h09;
         3'h5:    shiftOf = 5'h0c;
         3'h6:    shiftOf = 5'h0f;
         default: shiftOf = 5'h0c;
      endcase
   endfunction

   logic [2:0]  dataRate_ff;
   logic        clkDivSel_ff;
   logic [1:0]  chopSel_ff;
   logic [7:0]  devCnt_ff;
   logic [4:0]  modCnt_ff;
   logic [5:0]  chopCnt_ff;
   logic        devTick_ff;
   logic [9:0]  decCnt_ff;
   logic [1:0]  settleCnt_ff;
   logic        startD_ff;
   logic        overrun_ff;
   sdp_state_t  state_ff;
   logic [ACC_W-1:0] int1_ff [NUM_CH];
   logic [ACC_W-1:0] int2_ff [NUM_CH];
   logic [ACC_W-1:0] int3_ff [NUM_CH];
   logic [ACC_W-1:0] d1_ff   [NUM_CH];
   logic [ACC_W-1:0] d2_ff   [NUM_CH];
   logic [ACC_W-1:0] d3_ff   [NUM_CH];
   logic [OUT_W-1:0] sample  [NUM_CH];
   logic [31:0] fifoOut;
   logic        fifoValid, fifoReady;

   wire  [7:0] devDiv   = clkDivSel_ff ? DEV_TICK_FDIV : DEV_TICK_DIV;
   wire  [4:0] modDiv   = clkDivSel_ff ? MOD_DIV_FAST : MOD_DIV_SLOW;
   wire  [9:0] ratio    = ratioOf(dataRate_ff);
   wire  [5:0] chopDiv  = (chopSel_ff == 2'h0) ? 6'h02 :
                          (chopSel_ff == 2'h1) ? 6'h04 : 6'h10;
   wire        startRise = startIn && !startD_ff;
   wire        decEnd   = modTick_ff && (decCnt_ff == 10'(ratio - 1'b1));
   wire        emit     = decEnd && (state_ff == SDP_RUN);
   wire        busReq   = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire        wrReq    = busReq && wb_we_i && wb_sel_i[0];
   wire        dataRd   = busReq && !wb_we_i && (wb_adr_i == DATA_OFF);
   // Wrap on >= so a divisor switched lower cannot strand a counter
   wire        devWrap  = (devCnt_ff >= 8'(devDiv - 1'b1));
   wire        modWrap  = (modCnt_ff >= 5'(modDiv - 1'b1));
   wire        chopWrap = (chopCnt_ff >= 6'(chopDiv - 1'b1));
   wire  [4:0] rsh      = shiftOf(dataRate_ff);
   wire        lsh      = (dataRate_ff == 3'h0);

   // Device clock tick (512 kHz or 2.048 MHz) then modulator divider
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         devCnt_ff  <= '0;
         devTick_ff <= 1'b0;
         modCnt_ff  <= '0;
         modTick_ff <= 1'b0;
      end else begin
         devTick_ff <= devWrap;
         devCnt_ff  <= devWrap ? '0 : 8'(devCnt_ff + 1'b1);
         modTick_ff <= devTick_ff && modWrap;
         if (devTick_ff)
            modCnt_ff <= modWrap ? '0 : 5'(modCnt_ff + 1'b1);
      end
   end

   // Chopping clock: modulator ticks divided to 64/32/8 kHz-class rates
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         chopCnt_ff  <= '0;
         chopTick_ff <= 1'b0;
      end else begin
         chopTick_ff <= modTick_ff && chopWrap;
         if (modTick_ff)
            chopCnt_ff <= chopWrap ? '0 : 6'(chopCnt_ff + 1'b1);
      end
   end

   // Sinc3 per channel: integrators at modulator rate, combs at output rate
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : gCh
         wire [ACC_W-1:0] c1 = ACC_W'(int3_ff[g] - d1_ff[g]);
         wire [ACC_W-1:0] c2 = ACC_W'(c1 - d2_ff[g]);
         wire [ACC_W-1:0] c3 = ACC_W'(c2 - d3_ff[g]);
         // Bipolar input: bit 1 => +1, bit 0 => -1; full scale is +-N^3
         wire signed [ACC_W-1:0] sc = $signed(c3);
         wire [ACC_W-1:0] shifted = lsh ? ACC_W'(sc <<< 3) :
                                          ACC_W'(sc >>> rsh);
         wire signed [ACC_W-1:0] sv = $signed(shifted);
         assign sample[g] = (sv > $signed({16'h0000, POS_FS})) ? POS_FS :
                            (sv < -$signed({16'h0000, POS_FS})) ? NEG_FS :
                            sv[OUT_W-1:0];
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               int1_ff[g] <= '0;
               int2_ff[g] <= '0;
               int3_ff[g] <= '0;
               d1_ff[g]   <= '0;
               d2_ff[g]   <= '0;
               d3_ff[g]   <= '0;
            end else begin
               if (modTick_ff) begin
                  int1_ff[g] <= modBit[g] ? ACC_W'(int1_ff[g] + 1'b1)
                                          : ACC_W'(int1_ff[g] - 1'b1);
                  int2_ff[g] <= ACC_W'(int2_ff[g] + int1_ff[g]);
                  int3_ff[g] <= ACC_W'(int3_ff[g] + int2_ff[g]);
               end
               if (decEnd) begin
                  d1_ff[g] <= int3_ff[g];
                  d2_ff[g] <= c1;
                  d3_ff[g] <= c2;
               end
            end
         end
      end
   endgenerate

   // Start handling: comb history must refill for three periods
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         startD_ff    <= 1'b0;
         state_ff     <= SDP_IDLE;
         settleCnt_ff <= '0;
         decCnt_ff    <= '0;
      end else begin
         startD_ff <= startIn;
         if (modTick_ff)
            decCnt_ff <= decEnd ? '0 : 10'(decCnt_ff + 1'b1);
         case (state_ff)
            SDP_IDLE: if (startRise) begin
               state_ff     <= SDP_SETTLE;
               settleCnt_ff <= '0;
               decCnt_ff    <= '0;
            end
            SDP_SETTLE: if (decEnd) begin
               settleCnt_ff <= 2'(settleCnt_ff + 1'b1);
               if (settleCnt_ff == 2'(SETTLE_PER - 1)) state_ff <= SDP_RUN;
            end
            SDP_RUN: if (!startIn) state_ff <= SDP_IDLE;
            default: state_ff <= SDP_IDLE;
         endcase
         // A new ratio restarts the count so it never runs past the end
         if (wrReq && wb_adr_i == CFG1_OFF)
            decCnt_ff <= '0;
      end
   end

   // Samples queue for the readout; full FIFO drops and flags overrun
   sdp_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) uFifo (
      .clk      (clk),
      .resetn   (resetn),
      .inData   ({sample[1], sample[0]}),
      .inValid  (emit),
      .inReady  (fifoReady),
      .outData  (fifoOut),
      .outValid (fifoValid),
      .outReady (dataRd)
   );

   wire [31:0] rdMux =
      (wb_adr_i == CFG1_OFF)   ? {29'h0, dataRate_ff} :
      (wb_adr_i == GAIN1_OFF)  ? {25'h0, gainSel1_ff, 4'h0} :
      (wb_adr_i == GAIN2_OFF)  ? {25'h0, gainSel2_ff, 4'h0} :
      (wb_adr_i == LDSTAT_OFF) ? {25'h0, clkDivSel_ff, 6'h0} :
      (wb_adr_i == CTRL_OFF)   ? {30'h0, chopSel_ff} :
      (wb_adr_i == STAT_OFF)   ? {28'h0, overrun_ff, fifoValid,
                                  state_ff == SDP_RUN, startIn} :
      (wb_adr_i == DATA_OFF)   ? (fifoValid ? fifoOut : 32'h0) : 32'h0;

   // Wishbone classic slave: one wait state, ack for one cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wb_ack_o     <= 1'b0;
         wb_dat_o     <= '0;
         dataRate_ff  <= RATE_RST;
         gainSel1_ff  <= GAIN_RST;
         gainSel2_ff  <= GAIN_RST;
         clkDivSel_ff <= 1'b0;
         chopSel_ff   <= CHOP_RST;
         overrun_ff   <= 1'b0;
      end else begin
         wb_ack_o <= busReq;
         wb_dat_o <= busReq ? rdMux : 32'h0;
         if (emit && !fifoReady)
            overrun_ff <= 1'b1;
         else if (wrReq && wb_adr_i == STAT_OFF && wb_dat_i[3])
            overrun_ff <= 1'b0;
         if (wrReq && wb_adr_i == CFG1_OFF)
            dataRate_ff <= wb_dat_i[RATE_LSB +: 3];
         if (wrReq && wb_adr_i == GAIN1_OFF)
            gainSel1_ff <= gainClamp(wb_dat_i[GAIN_LSB +: 3], gainSel1_ff);
         if (wrReq && wb_adr_i == GAIN2_OFF)
            gainSel2_ff <= gainClamp(wb_dat_i[GAIN_LSB +: 3], gainSel2_ff);
         if (wrReq && wb_adr_i == LDSTAT_OFF)
            clkDivSel_ff <= wb_dat_i[CLKDIV_BIT];
         if (wrReq && wb_adr_i == CTRL_OFF)
            chopSel_ff <= wb_dat_i[CHOP_LSB +: 2];
      end
   end

   ackPulse_a: assert property (@(posedge clk) disable iff (!resetn)
      wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   clkDiv_a: assert property (@(posedge clk) disable iff (!resetn)
      modTick_ff |=> !modTick_ff [*3])
      else $error("modulator tick too close");
   gainLegal_a: assert property (@(posedge clk) disable iff (!resetn)
      gainSel1_ff != 3'h7 && gainSel2_ff != 3'h7)
      else $error("illegal gain code held");
   settle_a: assert property (@(posedge clk) disable iff (!resetn)
      startRise && state_ff == SDP_IDLE |=> !emit [*8])
      else $error("sample emitted without settling");
   satRange_a: assert property (@(posedge clk) disable iff (!resetn)
      emit && $signed(gCh[0].sv) > $signed({16'h0000, POS_FS})
      |-> sample[0] == POS_FS)
      else $error("sample not clipped at full scale");
   ratioCnt_a: assert property (@(posedge clk) disable iff (!resetn)
      decCnt_ff < ratio || $changed(dataRate_ff) ||
      $past(wb_ack_o))
      else $error("decimation counter ran past ratio");
   emitTick_a: assert property (@(posedge clk) disable iff (!resetn)
      emit |-> modTick_ff)
      else $error("output not aligned to modulator tick");
   chopOn_a: assert property (@(posedge clk) disable iff (!resetn)
      chopTick_ff |-> $past(modTick_ff))
      else $error("chop tick without modulator tick");
endmodule
`default_nettype wire

// ==== test/sdp_mod_model.sv ====
// Behavioural modulator standing in front of the sinc path.
// Assumes modTick is a one-cycle pulse in the clk domain.
`timescale 1ns/1ps
`default_nettype none
module sdp_mod_model (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       modTick,
   input  wire logic [1:0] level,
   output logic      [1:0] modBit
);
   logic [1:0] out_ff;
   assign modBit = out_ff;
   // Bits move only on a tick, never between two samples
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         out_ff <= 2'h0;
      end else if (modTick) begin
         out_ff <= level;
      end
   end
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the sinc3 path, driven over Wishbone.
// Assumes the register map of sdp_pkg and a modulator model.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import sdp_pkg::*;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat, d;
   logic        we = 1'b0;
   logic        cyc = 1'b0;
   logic        ack, modTick, chopTick;
   logic        startIn = 1'b0;
   logic [1:0]  level = 2'h1;
   logic [1:0]  modBit;
   logic [2:0]  g1, g2;
   int          err_count = 0;
   int          cmp_count = 0;
   int          m, p;
   longint      t0;
   always #12.5 clk = ~clk;
   sdp_sinc3_path u_sdp_sinc3_path (
      .clk(clk), .resetn(resetn), .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(4'hf), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_ack_o(ack), .startIn(startIn),
      .modBit(modBit), .modTick_ff(modTick), .chopTick_ff(chopTick),
      .gainSel1_ff(g1), .gainSel2_ff(g2));
   sdp_mod_model u_sdp_mod_model (
      .clk(clk), .resetn(resetn), .modTick(modTick), .level(level),
      .modBit(modBit));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("compares=%0d mismatches=%0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // One classic cycle; read data lands in d at the ack edge
   task automatic wb(input logic [7:0] a, input logic w,
                     input logic [31:0] v);
      int n;
      n = 0;
      adr <= a;
      we <= w;
      wdat <= v;
      cyc <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      d = rdat;
      cyc <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
      if (n >= 50) begin
         err_count++;
         print_verdict();
      end
   endtask
   task automatic waitStat(input int b, input int lim);
      int n;
      n = 0;
      do begin
         wb(STAT_OFF, 1'b0, 32'h0);
         n++;
      end while (d[b] !== 1'b1 && n < lim);
      if (d[b] !== 1'b1) begin
         err_count++;
         print_verdict();
      end
   endtask
   // Cycles between two pulses of the chosen tick
   task automatic per(input logic s, output int q);
      int n;
      n = 0;
      while ((s ? chopTick : modTick) !== 1'b1 && n < 6000) begin
         @(posedge clk);
         n++;
      end
      @(posedge clk);
      q = 1;
      while ((s ? chopTick : modTick) !== 1'b1 && q < 6000) begin
         @(posedge clk);
         q++;
      end
      if (n >= 6000 || q >= 6000) begin
         err_count++;
         print_verdict();
      end
   endtask
   initial begin
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      wb(CFG1_OFF, 1'b0, 32'h0);
      check(32'(d[2:0]), 32'(RATE_RST));
      check({g1, g2}, 6'h00);
      wb(8'h3c, 1'b0, 32'h0);
      check(d, 32'h0);
      $display("reset test done");
      for (int i = 0; i < 8; i++) begin
         wb(GAIN1_OFF, 1'b1, 32'(i) << 4);
         wb(GAIN2_OFF, 1'b1, 32'(i == 7 ? 7 : 6 - i) << 4);
         check({g1, g2}, i == 7 ? 6'h30 : 6'(i * 8 + 6 - i));
      end
      $display("gain test done");
      per(1'b0, m);
      check(32'(m), 32'(DEV_TICK_DIV) * 32'(MOD_DIV_SLOW));
      wb(LDSTAT_OFF, 1'b1, 32'h40);
      per(1'b0, p);
      check(32'(p), 32'(DEV_TICK_FDIV) * 32'(MOD_DIV_FAST));
      wb(LDSTAT_OFF, 1'b1, 32'h0);
      for (int c = 0; c < 3; c++) begin
         wb(CTRL_OFF, 1'b1, 32'(c));
         per(1'b1, p);
         check(32'(p), 32'((c == 0 ? 2 : c == 1 ? 4 : 16) * m));
      end
      $display("clock test done");
      wb(CFG1_OFF, 1'b1, 32'h0);
      startIn <= 1'b1;
      t0 = $time;
      waitStat(2, 9000);
      check(32'(($time - t0) / 25 >= 48 * m), 1);
      wb(DATA_OFF, 1'b0, 32'h0);
      check(d, {NEG_FS, POS_FS});
      level <= 2'h2;
      for (int k = 0; k < 4; k++) begin
         waitStat(2, 4000);
         wb(DATA_OFF, 1'b0, 32'h0);
      end
      check(d, {POS_FS, NEG_FS});
      $display("settle test done");
      repeat (96 * m) @(posedge clk);
      startIn <= 1'b0;
      wb(STAT_OFF, 1'b0, 32'h0);
      check(32'(d[3:2]), 32'h3);
      for (int k = 0; k < 4; k++) begin
         wb(DATA_OFF, 1'b0, 32'h0);
         check(d, {POS_FS, NEG_FS});
      end
      wb(STAT_OFF, 1'b0, 32'h0);
      check(32'(d[2]), 32'h0);
      wb(DATA_OFF, 1'b0, 32'h0);
      check(d, 32'h0);
      wb(STAT_OFF, 1'b1, 32'h8);
      wb(STAT_OFF, 1'b0, 32'h0);
      check(32'(d[3]), 32'h0);
      $display("fifo test done");
      print_verdict();
   end
endmodule
`default_nettype wire
